/* core/sfc_consts.svh */
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
// Contract
// - all four count bits change together, only on a clock_in rising edge; here soft clear and soft load from the bus also change them off the edge.
// - load_enable_n low loads load_value at the next rising edge, ignoring both enables; here the edge is skipped while freeze is set or a soft clear or load lands.
// - count only with load_enable_n high and both enables high; otherwise hold.
// - each load_value bit goes to its matching count_out bit on a preset.
// - while clock_in is low the outputs keep their old value during a preset.
// - on a counting rising edge the counter steps to its next sequence state; here the edge is skipped while freeze is set or a soft clear or load lands.
// - terminal_flag high only when count_enable_chain high and count at 9 or 15; here the flag lags count_enable_chain by one core_clk.
// - decade counter accepts any preset, never counts past nine, wraps nine to zero.
// - decade counter preset to ten through fifteen rejoins zero-to-nine within two pulses.
// - clear_n low forces count_out to zero at once, over clock and all inputs.

// widths
`define SFC_CNT_W 4
`define SFC_MODE_W 2
`define SFC_ADDR_W 8
`define SFC_DATA_W 32
`define SFC_STRB_W 4
`define SFC_LANE_W 8
`define SFC_EVT_W 16

// count values
`define SFC_ZERO_CNT 4'h0
`define SFC_ONE_CNT 4'h1
`define SFC_DEC_TERM 4'h9
`define SFC_BIN_TERM 4'hf

// register byte offsets
`define SFC_CTRL_OFS 8'h00
`define SFC_STATUS_OFS 8'h04
`define SFC_WRAPS_OFS 8'h08
`define SFC_RISES_OFS 8'h0c
`define SFC_INFO_OFS 8'h10

// field positions
`define SFC_CTRL_FREEZE_BIT 0
`define SFC_CTRL_CLEAR_BIT 1
`define SFC_CTRL_LOAD_BIT 2
`define SFC_CTRL_VALUE_LSB 4
`define SFC_STAT_COUNT_LSB 0
`define SFC_STAT_TERM_BIT 4
`define SFC_STAT_MODE_LSB 5
`define SFC_INFO_DECADE_BIT 0
`define SFC_INFO_TERM_LSB 4

// bus answers
`define SFC_RESP_OKAY 2'h0
`define SFC_RESP_DECERR 2'h3
`endif

/* core/sfc_pkg.sv */
`include "sfc_consts.svh"
package sfc_pkg;

  // mode picked at the last clock_in rising edge the core acted on (not frozen, no soft clear or load)
  typedef enum logic [`SFC_MODE_W-1:0] {SFC_HOLD, SFC_PRESET, SFC_COUNT} sfc_mode_e;

  // the counter's control pins, sampled together
  typedef struct packed {
    logic load_enable_n;
    logic [`SFC_CNT_W-1:0] load_value;
    logic count_enable_parallel;
    logic count_enable_chain;
  } sfc_pins_s;

  // software controls handed to the counter core
  typedef struct packed {
    logic freeze;
    logic soft_clear;
    logic soft_load;
    logic [`SFC_CNT_W-1:0] soft_value;
  } sfc_sw_s;

  // counter core state
  typedef struct packed {
    logic [`SFC_CNT_W-1:0] count;
    logic terminal;
    logic clk_prev;
    logic wrap;
    logic rise;
    sfc_mode_e mode;
  } sfc_core_s;

  // bus slave state
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [`SFC_DATA_W-1:0] rdata;
    logic aw_held;
    logic [`SFC_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [`SFC_DATA_W-1:0] wdata;
    logic [`SFC_STRB_W-1:0] wstrb;
    sfc_sw_s sw;
    logic [`SFC_EVT_W-1:0] wraps;
    logic [`SFC_EVT_W-1:0] rises;
  } sfc_bus_s;

endpackage : sfc_pkg

/* core/sfc_count_core.sv */
`timescale 1ns/1ps
`include "sfc_consts.svh"

module sfc_count_core
  import sfc_pkg::*;
#(
  parameter bit DECADE = 1'b1
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear_n,
  input wire logic clock_in,
  input wire sfc_pins_s pins,
  input wire sfc_sw_s sw,
  output sfc_core_s core_q
);

  sfc_core_s core_d;
  sfc_mode_e mode_now;
  logic rise;
  logic [`SFC_CNT_W-1:0] term_val;

  assign term_val = DECADE ? `SFC_DEC_TERM : `SFC_BIN_TERM;

  // next state of the count sequence for either variant
  function automatic logic [`SFC_CNT_W-1:0] next_count(input logic [`SFC_CNT_W-1:0] c);
    logic [`SFC_CNT_W-1:0] n;
    n = c + `SFC_ONE_CNT;
    if (DECADE && c == `SFC_DEC_TERM)
      n = `SFC_ZERO_CNT;
    else if (DECADE && c > `SFC_DEC_TERM)
      n = c[0] ? `SFC_ZERO_CNT : n; // odd illegal states fall to zero, even ones step once
    next_count = n; // binary rolls 15 to 0 by width
  endfunction : next_count

  // mode decode and the single-edge update of all four bits
  always_comb
  begin
    core_d = core_q;
    core_d.clk_prev = clock_in;
    core_d.wrap = 1'b0;
    rise = clock_in & ~core_q.clk_prev; // besides soft clear and soft load, only a low-to-high step of clock_in moves the count
    core_d.rise = rise;
    if (!pins.load_enable_n)
      mode_now = SFC_PRESET; // load wins over both enables
    else if (pins.count_enable_parallel && pins.count_enable_chain)
      mode_now = SFC_COUNT;
    else
      mode_now = SFC_HOLD;
    if (sw.soft_clear)
      core_d.count = `SFC_ZERO_CNT;
    else if (sw.soft_load)
      core_d.count = sw.soft_value;
    else if (rise && !sw.freeze)
    begin
      core_d.mode = mode_now; // pins are taken as sampled at the edge, stable while low
      case (mode_now)
        SFC_PRESET: core_d.count = pins.load_value; // bit for bit
        SFC_COUNT:
        begin
          core_d.count = next_count(core_q.count);
          core_d.wrap = (core_q.count == term_val);
        end
        default: core_d.count = core_q.count; // hold, also between edges
      endcase
    end
    core_d.terminal = pins.count_enable_chain && (core_d.count == term_val);
  end

  // clear_n acts without the clock; rst is synchronous
  always_ff @(posedge core_clk or negedge clear_n)
  begin
    if (!clear_n)
      core_q <= '0;
    else if (rst)
      core_q <= '0;
    else
      core_q <= core_d;
  end

endmodule : sfc_count_core

/* core/sfc_counter.sv */
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "sfc_consts.svh"

module sfc_counter
  import sfc_pkg::*;
#(
  parameter bit DECADE = 1'b1
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear_n,
  input wire logic clock_in,
  input wire logic load_enable_n,
  input wire logic [`SFC_CNT_W-1:0] load_value,
  input wire logic count_enable_parallel,
  input wire logic count_enable_chain,
  output logic [`SFC_CNT_W-1:0] count_out,
  output logic terminal_flag,
  input wire logic [`SFC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`SFC_DATA_W-1:0] s_axi_wdata,
  input wire logic [`SFC_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SFC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`SFC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  sfc_pins_s pins;
  sfc_core_s core_q;
  sfc_bus_s bus_q;
  sfc_bus_s bus_d;
  logic aw_fire;
  logic w_fire;
  logic b_fire;
  logic ar_fire;
  logic r_fire;
  logic commit;
  logic [`SFC_ADDR_W-1:0] wr_word;
  logic [`SFC_DATA_W-1:0] old_word;
  logic [`SFC_DATA_W-1:0] merged_word;
  logic [`SFC_EVT_W-1:0] wraps_next;
  logic [`SFC_EVT_W-1:0] rises_next;

  // the pins travel to the core as one group; one driver for the whole struct
  assign pins = {load_enable_n, load_value, count_enable_parallel, count_enable_chain};

  // the counter itself; it owns the asynchronous clear
  sfc_count_core #(
    .DECADE(DECADE)
  ) u_core (
    .core_clk(core_clk),
    .rst(rst),
    .clear_n(clear_n),
    .clock_in(clock_in),
    .pins(pins),
    .sw(bus_q.sw),
    .core_q(core_q)
  );

  // counter outputs come straight from the core flops
  assign count_out = core_q.count;
  assign terminal_flag = core_q.terminal;

  // bus outputs come straight from the slave flops
  assign s_axi_awready = bus_q.awready;
  assign s_axi_wready = bus_q.wready;
  assign s_axi_bvalid = bus_q.bvalid;
  assign s_axi_bresp = bus_q.bresp;
  assign s_axi_arready = bus_q.arready;
  assign s_axi_rvalid = bus_q.rvalid;
  assign s_axi_rresp = bus_q.rresp;
  assign s_axi_rdata = bus_q.rdata;

  // handshakes on the five channels
  assign aw_fire = s_axi_awvalid & bus_q.awready;
  assign w_fire = s_axi_wvalid & bus_q.wready;
  assign b_fire = bus_q.bvalid & s_axi_bready;
  assign ar_fire = s_axi_arvalid & bus_q.arready;
  assign r_fire = bus_q.rvalid & s_axi_rready;

  // a write lands once address and data are both held and no answer is pending
  assign commit = bus_q.aw_held & bus_q.w_held & ~bus_q.bvalid;
  assign wr_word = {bus_q.awaddr[`SFC_ADDR_W-1:2], 2'h0};

  // low address bits are ignored, so every access is one aligned word
  function automatic logic is_mapped(input logic [`SFC_ADDR_W-1:0] addr);
    logic [`SFC_ADDR_W-1:0] word_addr;
    word_addr = {addr[`SFC_ADDR_W-1:2], 2'h0};
    is_mapped = (word_addr == `SFC_CTRL_OFS) || (word_addr == `SFC_STATUS_OFS) ||
                (word_addr == `SFC_WRAPS_OFS) || (word_addr == `SFC_RISES_OFS) ||
                (word_addr == `SFC_INFO_OFS);
  endfunction : is_mapped

  // read view of every register; unused bits read as zero
  function automatic logic [`SFC_DATA_W-1:0] read_word(
    input logic [`SFC_ADDR_W-1:0] addr,
    input sfc_bus_s b,
    input sfc_core_s c,
    input logic decade
  );
    logic [`SFC_ADDR_W-1:0] word_addr;
    logic [`SFC_DATA_W-1:0] w;
    word_addr = {addr[`SFC_ADDR_W-1:2], 2'h0};
    w = '0;
    case (word_addr)
      `SFC_CTRL_OFS:
      begin
        // clear and load are pulses and always read back low
        w[`SFC_CTRL_FREEZE_BIT] = b.sw.freeze;
        w[`SFC_CTRL_VALUE_LSB +: `SFC_CNT_W] = b.sw.soft_value;
      end
      `SFC_STATUS_OFS:
      begin
        w[`SFC_STAT_COUNT_LSB +: `SFC_CNT_W] = c.count;
        w[`SFC_STAT_TERM_BIT] = c.terminal;
        w[`SFC_STAT_MODE_LSB +: `SFC_MODE_W] = c.mode;
      end
      `SFC_WRAPS_OFS:
      begin
        w[`SFC_EVT_W-1:0] = b.wraps;
      end
      `SFC_RISES_OFS:
      begin
        w[`SFC_EVT_W-1:0] = b.rises;
      end
      `SFC_INFO_OFS:
      begin
        w[`SFC_INFO_DECADE_BIT] = decade;
        w[`SFC_INFO_TERM_LSB +: `SFC_CNT_W] = decade ? `SFC_DEC_TERM : `SFC_BIN_TERM;
      end
      default:
      begin
        w = '0;
      end
    endcase
    read_word = w;
  endfunction : read_word

  // the word as it stands, for lanes whose strobe is low
  assign old_word = read_word(bus_q.awaddr, bus_q, core_q, DECADE);

  // byte-lane merge: only strobed lanes take the new data
  generate
    for (genvar g = 0; g < `SFC_STRB_W; g++)
    begin : g_lane
      assign merged_word[g*`SFC_LANE_W +: `SFC_LANE_W] =
        bus_q.wstrb[g] ? bus_q.wdata[g*`SFC_LANE_W +: `SFC_LANE_W] : old_word[g*`SFC_LANE_W +: `SFC_LANE_W];
    end
  endgenerate

  // event counters; an event in the clearing cycle counts as the first one after the clear
  always_comb
  begin
    wraps_next = bus_q.wraps + (core_q.wrap ? `SFC_EVT_W'(1) : `SFC_EVT_W'(0));
    rises_next = bus_q.rises + (core_q.rise ? `SFC_EVT_W'(1) : `SFC_EVT_W'(0));
    if (commit && wr_word == `SFC_WRAPS_OFS)
      wraps_next = core_q.wrap ? `SFC_EVT_W'(1) : `SFC_EVT_W'(0);
    if (commit && wr_word == `SFC_RISES_OFS)
      rises_next = core_q.rise ? `SFC_EVT_W'(1) : `SFC_EVT_W'(0);
  end

  // slave next state: address, data, write effects, answers and readies
  always_comb
  begin
    bus_d = bus_q;
    bus_d.sw.soft_clear = 1'b0; // both are one-cycle pulses into the core
    bus_d.sw.soft_load = 1'b0;
    bus_d.wraps = wraps_next;
    bus_d.rises = rises_next;

    // address and data are taken in either order and held until the write lands
    if (aw_fire)
    begin
      bus_d.aw_held = 1'b1;
      bus_d.awaddr = s_axi_awaddr;
    end
    if (w_fire)
    begin
      bus_d.w_held = 1'b1;
      bus_d.wdata = s_axi_wdata;
      bus_d.wstrb = s_axi_wstrb;
    end

    // apply the write and raise the answer in the same step
    if (commit)
    begin
      bus_d.aw_held = 1'b0;
      bus_d.w_held = 1'b0;
      bus_d.bvalid = 1'b1;
      bus_d.bresp = is_mapped(bus_q.awaddr) ? `SFC_RESP_OKAY : `SFC_RESP_DECERR;
      if (wr_word == `SFC_CTRL_OFS)
      begin
        bus_d.sw.freeze = merged_word[`SFC_CTRL_FREEZE_BIT];
        bus_d.sw.soft_clear = merged_word[`SFC_CTRL_CLEAR_BIT];
        bus_d.sw.soft_load = merged_word[`SFC_CTRL_LOAD_BIT];
        bus_d.sw.soft_value = merged_word[`SFC_CTRL_VALUE_LSB +: `SFC_CNT_W];
      end
    end
    else if (b_fire)
    begin
      bus_d.bvalid = 1'b0;
      bus_d.bresp = `SFC_RESP_OKAY;
    end

    // reads answer one cycle after the address is taken, data captured then
    if (ar_fire)
    begin
      bus_d.rvalid = 1'b1;
      bus_d.rdata = read_word(s_axi_araddr, bus_q, core_q, DECADE);
      bus_d.rresp = is_mapped(s_axi_araddr) ? `SFC_RESP_OKAY : `SFC_RESP_DECERR;
    end
    else if (r_fire)
    begin
      bus_d.rvalid = 1'b0;
      bus_d.rdata = '0;
      bus_d.rresp = `SFC_RESP_OKAY;
    end

    // readies close while a channel is held or an answer waits, so one write and one read at a time
    bus_d.awready = ~bus_d.aw_held & ~bus_d.bvalid;
    bus_d.wready = ~bus_d.w_held & ~bus_d.bvalid;
    bus_d.arready = ~bus_d.rvalid;
  end

  // slave registers; clear_n leaves the bus side alone
  always_ff @(posedge core_clk)
  begin
    if (rst)
      bus_q <= '0;
    else
      bus_q <= bus_d;
  end

endmodule : sfc_counter

/* testbench/sfc_counter_asserts.sv */
`timescale 1ns/1ps
`include "sfc_consts.svh"
module sfc_counter_asserts
  import sfc_pkg::*;
#(
  parameter bit DECADE = 1'b1
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear_n,
  input wire logic clock_in,
  input wire logic load_enable_n,
  input wire logic [3:0] load_value,
  input wire logic count_enable_parallel,
  input wire logic count_enable_chain,
  input wire logic [3:0] count_out,
  input wire logic terminal_flag,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  localparam logic [3:0] TERM = DECADE ? `SFC_DEC_TERM : `SFC_BIN_TERM;
  logic prev_q;
  logic b_prev_q;
  logic actl_q;
  logic wfrz_q;
  logic frz_q;
  logic ctl_w;
  logic rise;
  logic ok;
  logic en;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // edge memory and freeze shadow; freeze only changes when the write lands, not when it is taken
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      actl_q <= 1'b0;
      wfrz_q <= 1'b0;
      frz_q <= 1'b0;
    end
    else
    begin
      prev_q <= clock_in;
      b_prev_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        actl_q <= s_axi_awaddr[7:2] == 6'h00;
      if (s_axi_wvalid && s_axi_wready)
        wfrz_q <= s_axi_wstrb[0] ? s_axi_wdata[`SFC_CTRL_FREEZE_BIT] : frz_q;
      if (ctl_w)
        frz_q <= wfrz_q;
    end
  end
  // the core sees a control write in the first cycle of its answer; soft ops may move the count then
  assign ctl_w = s_axi_bvalid && !b_prev_q && actl_q;
  assign rise = clock_in && !prev_q;
  assign ok = rise && clear_n && !frz_q && !ctl_w;
  assign en = load_enable_n && count_enable_parallel && count_enable_chain;
  function automatic logic [3:0] nxt(input logic [3:0] c);
    if (!DECADE || c < 4'h9)
      return c + 4'h1;
    return (c == 4'h9 || c[0]) ? 4'h0 : c + 4'h1;
  endfunction : nxt
  property p_clear; !clear_n |-> count_out == 4'h0 && !terminal_flag; endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");
  property p_term; clear_n |-> terminal_flag == ($past(count_enable_chain) && count_out == TERM); endproperty
  a_term: assert property (p_term) else $error("terminal flag wrong");
  property p_preset; ok && !load_enable_n |=> count_out == $past(load_value); endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");
  property p_count; ok && en |=> count_out == nxt($past(count_out)); endproperty
  a_count: assert property (p_count) else $error("bad count step");
  property p_hold; ok && load_enable_n && !en |=> $stable(count_out); endproperty
  a_hold: assert property (p_hold) else $error("count moved without enables");
  property p_quiet; clear_n && !rise && !ctl_w |=> $stable(count_out) || !clear_n; endproperty
  a_quiet: assert property (p_quiet) else $error("count moved off a rise");
  property p_rejoin; DECADE && ok && en && count_out > 4'h9 |=> count_out == 4'h0 || count_out[0]; endproperty
  a_rejoin: assert property (p_rejoin) else $error("illegal state not left");
  property p_bresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("write response timing");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read response timing");
  c_wrap: cover property (ok && en && count_out == TERM);
  c_preset: cover property (ok && !load_enable_n);
  c_clear: cover property (!clear_n);
endmodule : sfc_counter_asserts

/* testbench/sfc_pin_driver.sv */
`timescale 1ns/1ps
module sfc_pin_driver
  import sfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire sfc_pins_s want,
  input wire logic [3:0] gap,
  output logic clock_in,
  output sfc_pins_s pins,
  output logic busy
);
  logic [4:0] left_q;
  assign busy = left_q != 5'h0;
  // one clock_in pulse per request after gap+2 low cycles; clock stays low when idle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      left_q <= 5'h0;
      clock_in <= 1'b0;
      pins <= '{1'b1, 4'h0, 1'b0, 1'b0};
    end
    else if (go)
    begin
      left_q <= {1'b0, gap} + 5'h3;
      clock_in <= 1'b0;
      pins <= want;
    end
    else if (busy)
    begin
      left_q <= left_q - 5'h1;
      clock_in <= left_q == 5'h2;
    end
  end
endmodule : sfc_pin_driver

/* testbench/test_sync_four_bit_counter.sv */
`timescale 1ns/1ps
`include "sfc_consts.svh"
module test_sync_four_bit_counter
  import sfc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clear_n = 1'b1;
  logic go = 1'b0;
  logic [3:0] gap = 4'h0;
  sfc_pins_s want = '0;
  sfc_pins_s pins;
  logic clock_in, busy, terminal_flag;
  logic [3:0] count_out, e;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [3:0] bin_count;
  logic bin_flag;
  int n_errors = 0;
  int total_checks = 0;
  always #5 core_clk = ~core_clk;
  sfc_pin_driver u_drv (.core_clk(core_clk), .rst(rst), .go(go), .want(want), .gap(gap),
    .clock_in(clock_in), .pins(pins), .busy(busy));
  sfc_counter #(.DECADE(1'b1)) dut (.core_clk(core_clk), .rst(rst), .clear_n(clear_n), .clock_in(clock_in),
    .load_enable_n(pins.load_enable_n), .load_value(pins.load_value),
    .count_enable_parallel(pins.count_enable_parallel), .count_enable_chain(pins.count_enable_chain),
    .count_out(count_out), .terminal_flag(terminal_flag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // binary variant on the same pins; its bus stays idle
  sfc_counter #(.DECADE(1'b0)) dut_bin (.core_clk(core_clk), .rst(rst), .clear_n(clear_n), .clock_in(clock_in),
    .load_enable_n(pins.load_enable_n), .load_value(pins.load_value),
    .count_enable_parallel(pins.count_enable_parallel), .count_enable_chain(pins.count_enable_chain),
    .count_out(bin_count), .terminal_flag(bin_flag), .s_axi_awaddr(8'h00), .s_axi_awvalid(1'b0),
    .s_axi_awready(), .s_axi_wdata(32'h0), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0),
    .s_axi_araddr(8'h00), .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic cnt(input logic [3:0] x, input logic f);
    @(negedge core_clk);
    chk({27'h0, terminal_flag, count_out}, {27'h0, f, x});
  endtask : cnt
  // one clock_in pulse; the count must not move while clock_in is still low
  task automatic step(input logic ld_n, input logic [3:0] v, input logic p, input logic t);
    logic [3:0] old;
    old = count_out;
    @(posedge core_clk);
    want <= '{ld_n, v, p, t};
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(negedge core_clk);
    chk({28'h0, count_out}, {28'h0, old});
    while (busy) @(negedge core_clk);
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // main sequence; load_value carries junk in the first counting loop to prove it is ignored
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(`SFC_INFO_OFS);
    chk(d, 32'h91);
    step(1'b0, 4'h7, 1'b0, 1'b0);
    cnt(4'h7, 1'b0);
    e = 4'h7;
    for (int i = 0; i < 4; i++)
    begin
      gap <= 4'(i * 5);
      step(1'b1, ~e, 1'b1, 1'b1);
      e = (e == 4'h9) ? 4'h0 : e + 4'h1;
      cnt(e, e == 4'h9);
    end
    step(1'b0, 4'h9, 1'b1, 1'b0);
    cnt(4'h9, 1'b0);
    step(1'b1, 4'h0, 1'b0, 1'b1);
    cnt(4'h9, 1'b1);
    step(1'b1, 4'h0, 1'b1, 1'b0);
    cnt(4'h9, 1'b0);
    for (int v = 10; v < 16; v++)
    begin
      step(1'b0, 4'(v), 1'b0, 1'b0);
      step(1'b1, 4'h0, 1'b1, 1'b1);
      cnt(v[0] ? 4'h0 : 4'(v + 1), 1'b0);
      step(1'b1, 4'h0, 1'b1, 1'b1);
      cnt(v[0] ? 4'h1 : 4'h0, 1'b0);
    end
    // both variants from fourteen: only the binary one flags fifteen
    step(1'b0, 4'he, 1'b0, 1'b0);
    cnt(4'he, 1'b0);
    step(1'b1, 4'h0, 1'b1, 1'b1);
    cnt(4'hf, 1'b0);
    chk({27'h0, bin_flag, bin_count}, {27'h0, 1'b1, 4'hf});
    step(1'b1, 4'h0, 1'b1, 1'b1);
    cnt(4'h0, 1'b0);
    chk({27'h0, bin_flag, bin_count}, {27'h0, 1'b0, 4'h0});
    @(posedge core_clk);
    clear_n <= 1'b0;
    #1 chk({28'h0, count_out}, 32'h0);
    @(posedge core_clk);
    clear_n <= 1'b1;
    wr(`SFC_CTRL_OFS, 32'h1);
    step(1'b0, 4'h6, 1'b0, 1'b0);
    cnt(4'h0, 1'b0);
    wr(`SFC_CTRL_OFS, 32'h54);
    cnt(4'h5, 1'b0);
    rd(`SFC_STATUS_OFS);
    chk(d & 32'h1f, 32'h5);
    // event counters cleared by any write, then five counting rises with one wrap
    wr(`SFC_WRAPS_OFS, 32'h0);
    wr(`SFC_RISES_OFS, 32'h0);
    repeat (5) step(1'b1, 4'h0, 1'b1, 1'b1);
    rd(`SFC_STATUS_OFS);
    chk(d, 32'h40);
    rd(`SFC_WRAPS_OFS);
    chk(d, 32'h1);
    rd(`SFC_RISES_OFS);
    chk(d, 32'h5);
    rd(8'h20);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `SFC_RESP_DECERR});
    wr(8'h20, 32'h0);
    chk({30'h0, r}, {30'h0, `SFC_RESP_DECERR});
    end_sim();
  end
  // the run needs a few hundred cycles; this allows ten thousand
  initial
  begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule : test_sync_four_bit_counter
bind sfc_counter sfc_counter_asserts #(.DECADE(DECADE)) u_chk (.*);
